//--- sse_pkg.sv
// shared constants for the shift/subtract/swap execution block
// assumes a byte-wide instruction stream and a 12-bit register file outside
package sse_pkg;

  // ****************************************
  // opcodes handled by this block
  // ****************************************
  localparam logic [7:0] OPC_LOAD_PTR = 8'h01;
  localparam logic [7:0] OPC_PREFIX   = 8'h1F;
  localparam logic [7:0] OPC_SHR_REG  = 8'hC0;
  localparam logic [7:0] OPC_SHR_IND  = 8'hC1;
  localparam logic [7:0] OPC_STOP     = 8'h6F;
  localparam logic [7:0] OPC_SUB_WW   = 8'h22;
  localparam logic [7:0] OPC_SUB_WI   = 8'h23;
  localparam logic [7:0] OPC_SUB_RR   = 8'h24;
  localparam logic [7:0] OPC_SUB_RI   = 8'h25;
  localparam logic [7:0] OPC_SUB_RM   = 8'h26;
  localparam logic [7:0] OPC_SUB_IM   = 8'h27;
  localparam logic [7:0] OPC_EXTENDED_MINUS_OP_EE  = 8'h28;
  localparam logic [7:0] OPC_EXTENDED_MINUS_OP_EM  = 8'h29;
  localparam logic [7:0] OPC_SWAP_REG = 8'hF0;
  localparam logic [7:0] OPC_SWAP_IND = 8'hF1;

  // ****************************************
  // escapes, reset values, operand counts
  // ****************************************
  localparam logic [3:0]  ESC_NIBBLE   = 4'hE;
  localparam logic [7:0]  ESC_EXT_BYTE = 8'hEE;
  localparam logic [7:0]  PTR_RESET    = 8'h00;
  localparam logic [11:0] ADDR_RESET   = 12'h000;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [1:0]  NEED_ONE     = 2'h1;
  localparam logic [1:0]  NEED_TWO     = 2'h2;
  localparam logic [1:0]  NEED_THREE   = 2'h3;

  // operand address forms
  typedef enum logic [1:0] {
    M_WORK = 2'h0,
    M_REG8 = 2'h1,
    M_EXT  = 2'h2,
    M_RAW  = 2'h3
  } sse_mode_t;

  // execution states, one-hot
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_PFX  = 8'h02,
    S_OPER = 8'h04,
    S_SRCP = 8'h08,
    S_SRCR = 8'h10,
    S_DSTP = 8'h20,
    S_DSTR = 8'h40,
    S_HALT = 8'h80
  } sse_state_t;

endpackage

//--- sse_addr_resolve.sv
// operand address resolver: turns an operand field into a 12-bit file address
// assumes group_page_pointer is stable while the address is in use
`timescale 1ns/1ps
module sse_addr_resolve
  import sse_pkg::*;
(
  // operand field
  input  wire sse_mode_t   mode,
  input  wire logic [11:0] val,
  // pointer: group in [7:4], page in [3:0]
  input  wire logic [7:0]  group_page_pointer,
  // resolved address
  output logic      [11:0] addr
);

  logic [11:0] work_addr;

  // working register sits at page, group, low nibble
  assign work_addr = {group_page_pointer[3:0], group_page_pointer[7:4], val[3:0]};

  // escape check per form; indirect targets are never escaped
  always_comb
  begin
    addr = work_addr;
    unique case (mode)
      M_WORK: addr = work_addr;
      M_REG8:
      begin
        if (val[7:4] == ESC_NIBBLE)
          addr = work_addr;
        else
          addr = {group_page_pointer[3:0], val[7:0]};
      end
      M_EXT:
      begin
        if (val[11:4] == ESC_EXT_BYTE)
          addr = work_addr;
        else
          addr = val;
      end
      M_RAW: addr = {group_page_pointer[3:0], val[7:0]};
    endcase
  end

endmodule

//--- sse_exec.sv
// execution logic for logical shift right, pointer load, stop,
// byte subtract (compact and extended forms) and nibble swap
// assumes the register file answers reads in the same cycle (combinational)
// and that instruction bytes arrive in stream order on byte_data
//
// Contract
// - shift right moves byte down one, old bit 0 to carry, top bit zero.
// - after shift: zero from result, sign cleared, overflow computed (code clears V instead), D and H kept.
// - shift uses prefix 1F then C0 or C1, then one address byte.
// - 8-bit address with upper nibble E selects working register by low nibble.
// - locations E0-EF reached only via group E or indirect addressing.
// - pointer load: upper nibble is group, lower nibble is page.
// - a group is sixteen consecutive locations; pointer F0 maps to 0F0-0FF.
// - halt opcode 6F enters stopped state, flags untouched.
// - subtract writes destination minus source; source left as is.
// - carry and half-carry from borrows; Z S V from result; D set.
// - compact subtracts on 22 to 27; full forms give source byte first.
// - extended subtract 28 and 29 with split 12-bit operand bytes.
// - 12-bit address with upper byte EE selects a working register.
// - E00-EFF reached in extended mode by page E and chosen group.
// - swap exchanges destination nibbles and writes back.
// - swap sets Z and S from result; D and H kept.
`timescale 1ns/1ps
module sse_exec
  import sse_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // instruction byte stream
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic             byte_ready,
  // register file read
  output logic             rf_rd_en,
  output logic      [11:0] rf_rd_addr,
  input  wire logic [7:0]  rf_rd_data,
  // register file write
  output logic             rf_wr_en,
  output logic      [11:0] rf_wr_addr,
  output logic      [7:0]  rf_wr_data,
  // condition flags
  output logic             flag_c,
  output logic             flag_z,
  output logic             flag_s,
  output logic             flag_v,
  output logic             flag_d,
  output logic             flag_h,
  // status and control
  output logic      [7:0]  group_page_pointer,
  output logic             stopped,
  output logic             busy,
  output logic             illegal_opcode,
  input  wire logic        stop_wake
);

  // ****************************************
  // state and storage
  // ****************************************
  sse_state_t  state_r;
  sse_state_t  state_nxt;
  logic [7:0]  opcode_r;
  logic [7:0]  b0_r;
  logic [7:0]  b1_r;
  logic [7:0]  b2_r;
  logic [1:0]  cnt_r;
  logic [7:0]  src_ptr_r;
  logic [7:0]  dst_ptr_r;
  logic [7:0]  src_val_r;
  logic [7:0]  ptr_r;
  logic        c_r, z_r, s_r, v_r, d_r, h_r;
  logic        wr_en_r;
  logic [11:0] wr_addr_r;
  logic [7:0]  wr_data_r;
  logic        illegal_r;

  // decode of held opcode
  logic        is_shr, is_swap, is_sub, is_srp;
  logic        src_ind, src_imm, dst_ind;
  logic [1:0]  need;
  logic [7:0]  imm;
  sse_mode_t   src_mode_b, dst_mode_b, src_mode, dst_mode;
  logic [11:0] src_val_b, dst_val_b, src_val, dst_val;
  logic [11:0] src_addr, dst_addr;
  logic        take, last_oper, known_op, pfx_ok;
  logic [7:0]  dv, sv, res;
  logic [8:0]  diff9;
  logic [4:0]  diff5;

  // ****************************************
  // opcode decode
  // ****************************************
  assign is_shr  = (opcode_r == OPC_SHR_REG) || (opcode_r == OPC_SHR_IND);
  assign is_swap = (opcode_r == OPC_SWAP_REG) || (opcode_r == OPC_SWAP_IND);
  assign is_sub  = (opcode_r >= OPC_SUB_WW) && (opcode_r <= OPC_EXTENDED_MINUS_OP_EM);
  assign is_srp  = (opcode_r == OPC_LOAD_PTR);
  assign src_ind = (opcode_r == OPC_SUB_WI) || (opcode_r == OPC_SUB_RI);
  assign src_imm = (opcode_r == OPC_SUB_RM) || (opcode_r == OPC_SUB_IM) || (opcode_r == OPC_EXTENDED_MINUS_OP_EM);
  assign dst_ind = (opcode_r == OPC_SUB_IM) || (opcode_r == OPC_SHR_IND) || (opcode_r == OPC_SWAP_IND);
  assign known_op = (byte_data == OPC_LOAD_PTR) || (byte_data == OPC_SWAP_REG) ||
                    (byte_data == OPC_SWAP_IND) ||
                    ((byte_data >= OPC_SUB_WW) && (byte_data <= OPC_EXTENDED_MINUS_OP_EM));
  assign pfx_ok  = (byte_data == OPC_SHR_REG) || (byte_data == OPC_SHR_IND);

  // operand layout per opcode; full forms carry source first
  always_comb
  begin
    need       = NEED_ONE;
    imm        = b1_r;
    src_mode_b = M_REG8;
    src_val_b  = {4'h0, b0_r};
    dst_mode_b = M_REG8;
    dst_val_b  = {4'h0, b0_r};
    unique case (opcode_r)
      OPC_SUB_WW, OPC_SUB_WI:
      begin
        src_mode_b = M_WORK;
        src_val_b  = {8'h00, b0_r[3:0]};
        dst_mode_b = M_WORK;
        dst_val_b  = {8'h00, b0_r[7:4]};
      end
      OPC_SUB_RR, OPC_SUB_RI:
      begin
        need      = NEED_TWO;
        dst_val_b = {4'h0, b1_r};
      end
      OPC_SUB_RM, OPC_SUB_IM: need = NEED_TWO;
      OPC_EXTENDED_MINUS_OP_EE, OPC_EXTENDED_MINUS_OP_EM:
      begin
        need       = NEED_THREE;
        imm        = b0_r;
        src_mode_b = M_EXT;
        src_val_b  = {b0_r, b1_r[7:4]};
        dst_mode_b = M_EXT;
        dst_val_b  = {b1_r[3:0], b2_r};
      end
      default: need = NEED_ONE;
    endcase
  end

  // indirect reads resolve the fetched pointer without escape
  assign src_mode = (src_ind && state_r == S_SRCR) ? M_RAW : src_mode_b;
  assign src_val  = (src_ind && state_r == S_SRCR) ? {4'h0, src_ptr_r} : src_val_b;
  assign dst_mode = (dst_ind && state_r == S_DSTR) ? M_RAW : dst_mode_b;
  assign dst_val  = (dst_ind && state_r == S_DSTR) ? {4'h0, dst_ptr_r} : dst_val_b;

  sse_addr_resolve u_src_res (
    .mode               (src_mode),
    .val                (src_val),
    .group_page_pointer (ptr_r),
    .addr               (src_addr)
  );

  sse_addr_resolve u_dst_res (
    .mode               (dst_mode),
    .val                (dst_val),
    .group_page_pointer (ptr_r),
    .addr               (dst_addr)
  );

  // ****************************************
  // sequencing
  // ****************************************
  assign byte_ready = (state_r == S_IDLE) || (state_r == S_PFX) || (state_r == S_OPER);
  assign take       = byte_valid && byte_ready;
  assign last_oper  = (cnt_r == need - NEED_ONE);

  // next state; stop parks until a wake request
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:
        if (take)
        begin
          if (byte_data == OPC_STOP)
            state_nxt = S_HALT;
          else if (byte_data == OPC_PREFIX)
            state_nxt = S_PFX;
          else if (known_op)
            state_nxt = S_OPER;
        end
      S_PFX:
        if (take)
          state_nxt = pfx_ok ? S_OPER : S_IDLE;
      S_OPER:
        if (take && last_oper)
        begin
          if (is_srp)
            state_nxt = S_IDLE;
          else if (src_ind)
            state_nxt = S_SRCP;
          else if (is_sub && !src_imm)
            state_nxt = S_SRCR;
          else if (dst_ind)
            state_nxt = S_DSTP;
          else
            state_nxt = S_DSTR;
        end
      S_SRCP: state_nxt = S_SRCR;
      S_SRCR: state_nxt = dst_ind ? S_DSTP : S_DSTR;
      S_DSTP: state_nxt = S_DSTR;
      S_DSTR: state_nxt = S_IDLE;
      S_HALT:
        if (stop_wake)
          state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state_r <= S_IDLE;
    else
      state_r <= state_nxt;
  end

  // opcode and operand capture
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      opcode_r <= BYTE_RESET;
      b0_r     <= BYTE_RESET;
      b1_r     <= BYTE_RESET;
      b2_r     <= BYTE_RESET;
      cnt_r    <= 2'h0;
    end
    else if (take)
    begin
      if (state_r != S_OPER)
      begin
        opcode_r <= byte_data;
        cnt_r    <= 2'h0;
      end
      else
      begin
        cnt_r <= cnt_r + NEED_ONE;
        unique case (cnt_r)
          2'h0:    b0_r <= byte_data;
          2'h1:    b1_r <= byte_data;
          default: b2_r <= byte_data;
        endcase
      end
    end
  end

  // pointer, source and destination reads from the register file
  assign rf_rd_en   = (state_r == S_SRCP) || (state_r == S_SRCR) ||
                      (state_r == S_DSTP) || (state_r == S_DSTR);
  assign rf_rd_addr = ((state_r == S_SRCP) || (state_r == S_SRCR)) ? src_addr : dst_addr;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      src_ptr_r <= BYTE_RESET;
      dst_ptr_r <= BYTE_RESET;
      src_val_r <= BYTE_RESET;
    end
    else
    begin
      if (state_r == S_SRCP)
        src_ptr_r <= rf_rd_data;
      if (state_r == S_SRCR)
        src_val_r <= rf_rd_data;                  // source only read, never written
      if (state_r == S_DSTP)
        dst_ptr_r <= rf_rd_data;
    end
  end

  // pointer load on the immediate byte; flags untouched
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      ptr_r <= PTR_RESET;
    else if (state_r == S_OPER && take && is_srp)
      ptr_r <= byte_data;
  end

  // ****************************************
  // arithmetic and write-back
  // ****************************************
  assign dv    = rf_rd_data;
  assign sv    = src_imm ? imm : src_val_r;
  assign diff9 = {1'b0, dv} - {1'b0, sv};
  assign diff5 = {1'b0, dv[3:0]} - {1'b0, sv[3:0]};

  // result mux
  always_comb
  begin
    res = diff9[7:0];
    if (is_shr)
      res = {1'b0, dv[7:1]};
    else if (is_swap)
      res = {dv[3:0], dv[7:4]};
  end

  // flag update happens only at destination read
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      c_r <= 1'b0;
      z_r <= 1'b0;
      s_r <= 1'b0;
      v_r <= 1'b0;
      d_r <= 1'b0;
      h_r <= 1'b0;
    end
    else if (state_r == S_DSTR)
    begin
      z_r <= (res == BYTE_RESET);
      if (is_shr)
      begin
        c_r <= dv[0];
        s_r <= 1'b0;
        v_r <= 1'b0;                              // no signed overflow in a logical shift
      end
      else if (is_swap)
        s_r <= res[7];                            // c, v kept as undefined
      else
      begin
        c_r <= diff9[8];
        h_r <= diff5[4];
        s_r <= res[7];
        v_r <= (dv[7] != sv[7]) && (res[7] != dv[7]);
        d_r <= 1'b1;
      end
    end
  end

  // registered write port, one pulse per executed shift, subtract or swap
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_en_r   <= 1'b0;
      wr_addr_r <= ADDR_RESET;
      wr_data_r <= BYTE_RESET;
    end
    else
    begin
      wr_en_r <= (state_r == S_DSTR);
      if (state_r == S_DSTR)
      begin
        wr_addr_r <= dst_addr;
        wr_data_r <= res;
      end
    end
  end

  // unknown opcode or bad prefix follow-on: one-cycle pulse
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      illegal_r <= 1'b0;
    else
      illegal_r <= take && (((state_r == S_IDLE) && !known_op && (byte_data != OPC_STOP) &&
                   (byte_data != OPC_PREFIX)) || ((state_r == S_PFX) && !pfx_ok));
  end

  assign rf_wr_en           = wr_en_r;
  assign rf_wr_addr         = wr_addr_r;
  assign rf_wr_data         = wr_data_r;
  assign flag_c             = c_r;
  assign flag_z             = z_r;
  assign flag_s             = s_r;
  assign flag_v             = v_r;
  assign flag_d             = d_r;
  assign flag_h             = h_r;
  assign group_page_pointer = ptr_r;
  assign stopped            = (state_r == S_HALT);
  assign busy               = !byte_ready && (state_r != S_HALT);
  assign illegal_opcode     = illegal_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_shr_data;
    (state_r == S_DSTR && is_shr) |=> (rf_wr_data == {1'b0, $past(dv[7:1])}) && (flag_c == $past(dv[0]));
  endproperty
  a_shr_data: assert property (p_shr_data) else $error("shift result or carry wrong");

  property p_shr_flags;
    (state_r == S_DSTR && is_shr) |=> !flag_s && $stable(flag_d) && $stable(flag_h);
  endproperty
  a_shr_flags: assert property (p_shr_flags) else $error("shift flags wrong");

  property p_esc8;
    (state_r == S_DSTR && opcode_r == OPC_SUB_RR && b1_r[7:4] == ESC_NIBBLE)
      |=> rf_wr_addr == {ptr_r[3:0], ptr_r[7:4], $past(b1_r[3:0])};
  endproperty
  a_esc8: assert property (p_esc8) else $error("escaped 8-bit address wrong");

  property p_ptr_load;
    (state_r == S_OPER && take && is_srp) |=> (group_page_pointer == $past(byte_data)) && (state_r == S_IDLE);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_ptr_flags;
    (state_r == S_OPER && take && is_srp) |=> $stable({flag_c, flag_z, flag_s, flag_v, flag_d, flag_h});
  endproperty
  a_ptr_flags: assert property (p_ptr_flags) else $error("pointer load changed flags");

  property p_stop;
    (state_r == S_IDLE && take && byte_data == OPC_STOP)
      |=> stopped && !byte_ready && $stable({flag_c, flag_z, flag_s, flag_v, flag_d, flag_h});
  endproperty
  a_stop: assert property (p_stop) else $error("stop not entered cleanly");

  property p_sub_flags;
    (state_r == S_DSTR && is_sub)
      |=> flag_d && (flag_c == ($past(dv) < $past(sv))) && (flag_h == ($past(dv[3:0]) < $past(sv[3:0])));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

  property p_sub_data;
    (state_r == S_DSTR && is_sub) |=> rf_wr_en && (rf_wr_data == 8'($past(dv) - $past(sv)));
  endproperty
  a_sub_data: assert property (p_sub_data) else $error("subtract result wrong");

  property p_escx;
    (state_r == S_DSTR && opcode_r == OPC_EXTENDED_MINUS_OP_EE && {b1_r[3:0], b2_r[7:4]} == ESC_EXT_BYTE)
      |=> rf_wr_addr == {ptr_r[3:0], ptr_r[7:4], $past(b2_r[3:0])};
  endproperty
  a_escx: assert property (p_escx) else $error("escaped 12-bit address wrong");

  property p_swap;
    (state_r == S_DSTR && is_swap)
      |=> (rf_wr_data == {$past(dv[3:0]), $past(dv[7:4])}) && $stable(flag_c) && $stable(flag_v) && $stable(flag_h);
  endproperty
  a_swap: assert property (p_swap) else $error("swap result or flags wrong");

  c_shr:  cover property (state_r == S_DSTR && opcode_r == OPC_SHR_IND);
  c_extended_minus_op: cover property (state_r == S_DSTR && opcode_r == OPC_EXTENDED_MINUS_OP_EE);
  c_swap: cover property (state_r == S_DSTR && is_swap);
  c_stop: cover property (stopped ##1 stop_wake);

endmodule

//--- sse_rf_model.sv
// behavioural byte-wide register file facing the exec block
// assumes reads answer in the same cycle and writes land on the edge
`timescale 1ns/1ps
module sse_rf_model
  import sse_pkg::*;
(
  // clock
  input  wire logic        core_clk,
  // read port
  input  wire logic        rf_rd_en,
  input  wire logic [11:0] rf_rd_addr,
  output logic      [7:0]  rf_rd_data,
  // write port
  input  wire logic        rf_wr_en,
  input  wire logic [11:0] rf_wr_addr,
  input  wire logic [7:0]  rf_wr_data
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0] mem [0:4095];
  logic [7:0] last_r = 8'h5A;
  // idle port shows the inverse of the last byte, so stale data never passes
  assign rf_rd_data = rf_rd_en ? mem[rf_rd_addr] : ~last_r;
  // writes and read tracking
  always @(posedge core_clk)
  begin
    if (rf_rd_en)
      last_r <= mem[rf_rd_addr];
    if (rf_wr_en)
      mem[rf_wr_addr] <= rf_wr_data;
  end
endmodule

//--- test_sse_exec.sv
// self-checking bench for the shift/subtract/swap exec block
// assumes the register file model holds all 4096 bytes
`timescale 1ns/1ps
module test_sse_exec
  import sse_pkg::*;
;
  // ****************************************
  // signals, design and partner
  // ****************************************
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        byte_valid = 1'b0;
  logic [7:0]  byte_data = 8'h00;
  logic        stop_wake = 1'b0;
  logic        byte_ready, rf_rd_en, rf_wr_en, stopped, busy, illegal_opcode;
  logic        flag_c, flag_z, flag_s, flag_v, flag_d, flag_h;
  logic [11:0] rf_rd_addr, rf_wr_addr;
  logic [7:0]  rf_rd_data, rf_wr_data, group_page_pointer;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [7:0]  sh [0:4095];
  logic [7:0]  ptr = 8'h00;
  logic [5:0]  fl = 6'h00;
  logic [25:0] exp_q [$];
  logic [7:0]  bq [$];
  localparam logic [7:0] OPS [13] = '{OPC_LOAD_PTR, OPC_SUB_WW, OPC_SUB_WI, OPC_SUB_RR, OPC_SUB_RI,
    OPC_SUB_RM, OPC_SUB_IM, OPC_EXTENDED_MINUS_OP_EE, OPC_EXTENDED_MINUS_OP_EM, OPC_SHR_REG, OPC_SHR_IND, OPC_SWAP_REG, OPC_SWAP_IND};

  always #20 core_clk = ~core_clk;

  sse_exec i_dut (.core_clk(core_clk), .nrst(nrst), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr), .rf_rd_data(rf_rd_data),
    .rf_wr_en(rf_wr_en), .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data), .flag_c(flag_c),
    .flag_z(flag_z), .flag_s(flag_s), .flag_v(flag_v), .flag_d(flag_d), .flag_h(flag_h),
    .group_page_pointer(group_page_pointer), .stopped(stopped), .busy(busy),
    .illegal_opcode(illegal_opcode), .stop_wake(stop_wake));

  sse_rf_model i_rf (.core_clk(core_clk), .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr),
    .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en), .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data));

  // ****************************************
  // address model and helpers
  // ****************************************
  function automatic logic [11:0] wk(input logic [3:0] n);
    return {ptr[3:0], ptr[7:4], n};
  endfunction
  function automatic logic [11:0] r8(input logic [7:0] a);
    return (a[7:4] == ESC_NIBBLE) ? wk(a[3:0]) : {ptr[3:0], a};
  endfunction
  function automatic logic [11:0] ind(input logic [7:0] a);
    return {ptr[3:0], sh[r8(a)]};
  endfunction
  function automatic logic [11:0] ext(input logic [11:0] x);
    return (x[11:4] == ESC_EXT_BYTE) ? wk(x[3:0]) : x;
  endfunction

  task automatic chk(input logic [25:0] got, input logic [25:0] want);
    total_checks++;
    if (got !== want)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, want);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // offers queued bytes; valid stays up between bytes so nothing is assigned twice
  task automatic send_all();
    int n;
    while (bq.size() > 0)
    begin
      byte_valid = 1'b1;
      byte_data = bq.pop_front();
      n = 0;
      while (byte_ready !== 1'b1 && n < 50)
      begin
        @(posedge core_clk);
        #2;
        n++;
      end
      @(posedge core_clk);
      #2;
    end
  endtask

  // builds one instruction, notes its expected write, then sends it
  task automatic do_op(input logic [7:0] op);
    logic [7:0]  a, b, dv, sv, r;
    logic [11:0] da, sa, x, y;
    a = 8'($urandom);
    b = 8'($urandom);
    x = 12'($urandom);
    y = 12'($urandom);
    sa = 12'h000;
    if ($urandom % 3 == 0) a[7:4] = ESC_NIBBLE;
    if ($urandom % 3 == 0) b[7:4] = ESC_NIBBLE;
    if ($urandom % 3 == 0) x[11:4] = ESC_EXT_BYTE;
    if ($urandom % 3 == 0) y[11:4] = ESC_EXT_BYTE;
    bq.push_back(op);
    case (op)
      OPC_LOAD_PTR:
      begin
        ptr = {a[7:4], b[7:4]};
        bq.push_back(ptr);
      end
      OPC_SUB_WW, OPC_SUB_WI:
      begin
        da = wk(a[7:4]);
        sa = (op == OPC_SUB_WW) ? wk(a[3:0]) : {ptr[3:0], sh[wk(a[3:0])]};
        bq.push_back(a);
      end
      OPC_SUB_RR, OPC_SUB_RI, OPC_SUB_RM, OPC_SUB_IM:
      begin
        sa = (op == OPC_SUB_RR) ? r8(a) : ind(a);
        da = op[1] ? (op[0] ? ind(a) : r8(a)) : r8(b);
        bq.push_back(a);
        bq.push_back(b);
      end
      OPC_EXTENDED_MINUS_OP_EE, OPC_EXTENDED_MINUS_OP_EM:
      begin
        sa = ext(x);
        da = ext(y);
        bq.push_back(op[0] ? a : x[11:4]);
        bq.push_back({op[0] ? 4'h0 : x[3:0], y[11:8]});
        bq.push_back(y[7:0]);
      end
      default:
      begin
        da = op[0] ? ind(a) : r8(a);
        if (op[7:4] == 4'hC) bq.push_front(OPC_PREFIX);
        bq.push_back(a);
      end
    endcase
    if (op != OPC_LOAD_PTR)
    begin
      dv = sh[da];
      sv = (op == OPC_SUB_RM || op == OPC_SUB_IM) ? b : (op == OPC_EXTENDED_MINUS_OP_EM) ? a : sh[sa];
      if (op[7:4] == 4'h2)
      begin
        r = dv - sv;
        fl = {dv < sv, r == 8'h00, r[7], (dv[7] ^ sv[7]) & (r[7] ^ dv[7]), 1'b1, dv[3:0] < sv[3:0]};
      end
      else if (op[7:4] == 4'hC)
      begin
        r = {1'b0, dv[7:1]};
        fl = {dv[0], r == 8'h00, 1'b0, 1'b0, fl[1:0]};
      end
      else
      begin
        r = {dv[3:0], dv[7:4]};
        fl = {fl[5], r == 8'h00, r[7], fl[2:0]};
      end
      sh[da] = r;
      exp_q.push_back({da, r, fl});
    end
    send_all();
  endtask

  // ****************************************
  // result watcher and timeout
  // ****************************************
  // every write pulse takes the oldest note; a write with no note fails
  always
  begin
    @(posedge core_clk);
    #1;
    if (nrst === 1'b1 && rf_wr_en === 1'b1)
      chk({rf_wr_addr, rf_wr_data, flag_c, flag_z, flag_s, flag_v, flag_d, flag_h},
          exp_q.size() > 0 ? exp_q.pop_front() : 26'bx);
  end

  // ceiling well above the ~1800 cycles the sequence needs
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(21696));
    for (int i = 0; i < 4096; i++)
    begin
      sh[i] = 8'($urandom);
      i_rf.mem[i] = sh[i];
    end
    repeat (12) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    chk(26'({stopped, flag_c, flag_z, flag_s, flag_v, flag_d, flag_h, group_page_pointer}), 26'h0);
    for (int i = 0; i < 400; i++)
      do_op(i < 13 ? OPS[i] : OPS[$urandom % 13]);
    // a two-read subtract holds the stream off while it fetches
    do_op(OPC_SUB_RR);
    chk(26'({busy, byte_ready}), 26'h2);
    byte_valid = 1'b0;
    repeat (8) @(posedge core_clk);
    #2;
    chk(26'(exp_q.size()), 26'h0);
    chk(26'(group_page_pointer), 26'(ptr));
    // halt refuses bytes until woken, flags untouched
    bq.push_back(OPC_STOP);
    send_all();
    chk(26'(stopped), 26'h1);
    repeat (3) @(posedge core_clk);
    #2;
    chk(26'({busy, byte_ready, flag_c, flag_z, flag_s, flag_v, flag_d, flag_h}), 26'(fl));
    byte_valid = 1'b0;
    stop_wake = 1'b1;
    @(posedge core_clk);
    #2;
    stop_wake = 1'b0;
    chk(26'(stopped), 26'h0);
    bq.push_back(8'h00);
    send_all();
    chk(26'(illegal_opcode), 26'h1);
    bq.push_back(OPC_PREFIX);
    bq.push_back(8'h55);
    send_all();
    chk(26'(illegal_opcode), 26'h1);
    byte_valid = 1'b0;
    repeat (4) @(posedge core_clk);
    #2;
    chk(26'({exp_q.size() == 0, flag_c, flag_z, flag_s, flag_v, flag_d, flag_h}), 26'({1'b1, fl}));
    conclude();
  end
endmodule
